// *** hw/lpmf_filter.sv ***
// aggregation and conversation port mask filter with its tables
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`include "lpmf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module lpmf_filter
   import lpmf_pkg::*;
#(
   parameter int PORTS   = 8,   // physical ports served
   parameter int COUNT_W = 8    // width of a member count entry
) (
   input  wire logic                    ref_clk,    // 10 MHz core clock
   input  wire logic                    reset,      // async, active high
   input  wire logic [`LPMF_ADDR_W-1:0] reg_addr,   // register word address
   input  wire logic [`LPMF_DATA_W-1:0] reg_wdata,  // register write data
   input  wire logic                    reg_write,  // write strobe
   input  wire logic                    reg_read,   // read strobe
   output logic      [`LPMF_DATA_W-1:0] reg_rdata,  // read data, next cycle
   input  wire lpmf_req_type            frame_req,  // frame from classifier
   output lpmf_res_type                 frame_res   // mask to forwarder
);

   localparam int CSD_AW  = $clog2(`LPMF_CSD_DEPTH);
   localparam int AGGR_AW = $clog2(`LPMF_AGGR_DEPTH);
   localparam int RST_AW  = $clog2(`LPMF_RST_DEPTH);
   localparam int GRP_AW  = $clog2(`LPMF_GROUPS);

   if (PORTS < 1 || PORTS > `LPMF_MAX_PORTS) begin : g_ports_check
      $error("PORTS must lie between 1 and the mask width");
   end
   if (COUNT_W < 1 || COUNT_W > `LPMF_DATA_W) begin : g_count_check
      $error("COUNT_W must lie between 1 and the data width");
   end

   typedef logic [PORTS-1:0] lpmf_mask_type;

   // ---------------------------------------------------------------
   // address decoding
   // ---------------------------------------------------------------
   function automatic logic in_range(input logic [`LPMF_ADDR_W-1:0] addr,
                                     input logic [`LPMF_ADDR_W-1:0] base,
                                     input int                      depth);
      in_range = (addr >= base) &&
                 ({1'b0, addr} < ({1'b0, base} + (`LPMF_ADDR_W+1)'(depth)));
   endfunction

   // ---------------------------------------------------------------
   // register file
   // ---------------------------------------------------------------
   logic [`LPMF_CTRL_W-1:0] ctrl_reg, ctrl_next;
   lpmf_mask_type           csd_reg  [`LPMF_CSD_DEPTH];
   lpmf_mask_type           csd_next [`LPMF_CSD_DEPTH];
   lpmf_mask_type           aggr_reg [`LPMF_AGGR_DEPTH];
   lpmf_mask_type           aggr_next[`LPMF_AGGR_DEPTH];
   lpmf_mask_type           rst_reg  [`LPMF_RST_DEPTH];
   lpmf_mask_type           rst_next [`LPMF_RST_DEPTH];
   logic [COUNT_W-1:0]      count_reg [`LPMF_GROUPS];
   logic [COUNT_W-1:0]      count_next[`LPMF_GROUPS];
   logic [`LPMF_DATA_W-1:0] rdata_reg, rdata_next;
   lpmf_mask_type           status_reg, status_next;

   always_comb begin
      ctrl_next  = ctrl_reg;
      csd_next   = csd_reg;
      aggr_next  = aggr_reg;
      rst_next   = rst_reg;
      count_next = count_reg;
      rdata_next = '0;
      if (reg_write) begin
         if (reg_addr == `LPMF_CTRL_ADDR) begin
            ctrl_next = reg_wdata[`LPMF_CTRL_W-1:0];
         end else if (in_range(reg_addr, `LPMF_AGGR_BASE,
                               `LPMF_AGGR_DEPTH)) begin
            aggr_next[reg_addr[AGGR_AW-1:0]] = reg_wdata[PORTS-1:0];
         end else if (in_range(reg_addr, `LPMF_RST_BASE,
                               `LPMF_RST_DEPTH)) begin
            rst_next[reg_addr[RST_AW-1:0]] = reg_wdata[PORTS-1:0];
         end else if (in_range(reg_addr, `LPMF_COUNT_BASE,
                               `LPMF_GROUPS)) begin
            count_next[reg_addr[GRP_AW-1:0]] = reg_wdata[COUNT_W-1:0];
         end else if (in_range(reg_addr, `LPMF_CSD_BASE,
                               `LPMF_CSD_DEPTH)) begin
            csd_next[reg_addr[CSD_AW-1:0]] = reg_wdata[PORTS-1:0];
         end
      end
      // unmapped addresses read as zero, writes to them are dropped
      if (reg_read) begin
         if (reg_addr == `LPMF_CTRL_ADDR) begin
            rdata_next = `LPMF_DATA_W'(ctrl_reg);
         end else if (reg_addr == `LPMF_STATUS_ADDR) begin
            rdata_next = `LPMF_DATA_W'(status_reg);
         end else if (in_range(reg_addr, `LPMF_AGGR_BASE,
                               `LPMF_AGGR_DEPTH)) begin
            rdata_next = `LPMF_DATA_W'(aggr_reg[reg_addr[AGGR_AW-1:0]]);
         end else if (in_range(reg_addr, `LPMF_RST_BASE,
                               `LPMF_RST_DEPTH)) begin
            rdata_next = `LPMF_DATA_W'(rst_reg[reg_addr[RST_AW-1:0]]);
         end else if (in_range(reg_addr, `LPMF_COUNT_BASE,
                               `LPMF_GROUPS)) begin
            rdata_next = `LPMF_DATA_W'(count_reg[reg_addr[GRP_AW-1:0]]);
         end else if (in_range(reg_addr, `LPMF_CSD_BASE,
                               `LPMF_CSD_DEPTH)) begin
            rdata_next = `LPMF_DATA_W'(csd_reg[reg_addr[CSD_AW-1:0]]);
         end
      end
   end

   // aggregation and distribution masks reset to all ones, reset masks to zero, so that an unprogrammed table keeps every port
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ctrl_reg  <= `LPMF_CTRL_RESET;
         rdata_reg <= '0;
         for (int i = 0; i < `LPMF_CSD_DEPTH; i++) begin
            csd_reg[i] <= '1;
         end
         for (int i = 0; i < `LPMF_AGGR_DEPTH; i++) begin
            aggr_reg[i] <= '1;
         end
         for (int i = 0; i < `LPMF_RST_DEPTH; i++) begin
            rst_reg[i] <= '0;
         end
         for (int i = 0; i < `LPMF_GROUPS; i++) begin
            count_reg[i] <= '0;
         end
      end else begin
         ctrl_reg  <= ctrl_next;
         rdata_reg <= rdata_next;
         csd_reg   <= csd_next;
         aggr_reg  <= aggr_next;
         rst_reg   <= rst_next;
         count_reg <= count_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ---------------------------------------------------------------
   // mask datapath
   // ---------------------------------------------------------------
   lpmf_source_type       conv_src;
   logic [`LPMF_VID_W-1:0] conv_id;
   lpmf_mask_type         csd_sel, aggr_sel, rst_sel;
   lpmf_mask_type         csd_adj, aggr_adj, final_mask;
   logic                  bypass;
   lpmf_res_type          res_reg, res_next;

   assign conv_src = lpmf_source_type'(ctrl_reg[`LPMF_SEL_MSB:`LPMF_SEL_LSB]);

   always_comb begin
      // pushed tags never reach this list, so only pops move the outer tag
      case (conv_src)
         LPMF_SRC_OUTER: begin
            if (frame_req.tag_pop_count < frame_req.tag_count) begin
               conv_id = frame_req.tag_vid[frame_req.tag_pop_count];
            end else begin
               conv_id = '0;
            end
         end
         LPMF_SRC_GENERIC: begin
            conv_id = frame_req.generic_vlan_id;
         end
         default: begin
            conv_id = frame_req.classified_vid;
         end
      endcase
      csd_sel  = csd_reg[conv_id];
      aggr_sel = aggr_reg[frame_req.aggregation_hash_code];
      rst_sel  = rst_reg[frame_req.forwarder_group_profile];
      bypass   = ctrl_reg[`LPMF_BYPASS_BIT] &&
                 (frame_req.mask_mode == `LPMF_REDIRECT_MODE);
      // either selection method can be switched off on its own
      if (ctrl_reg[`LPMF_AGGR_EN_BIT] && !bypass) begin
         aggr_adj = aggr_sel & ~rst_sel;
      end else begin
         aggr_adj = '1;
      end
      if (ctrl_reg[`LPMF_CSD_EN_BIT] && !bypass) begin
         csd_adj = csd_sel & ~rst_sel;
      end else begin
         csd_adj = '1;
      end
      final_mask = frame_req.dest_mask[PORTS-1:0] & aggr_adj & csd_adj;
      res_next.valid     = frame_req.valid;
      res_next.dest_mask = frame_req.valid ?
                           `LPMF_MAX_PORTS'(final_mask) : '0;
      status_next = frame_req.valid ? final_mask : status_reg;
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         res_reg    <= '0;
         status_reg <= '0;
      end else begin
         res_reg    <= res_next;
         status_reg <= status_next;
      end
   end

   assign frame_res = res_reg;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_result_latency: assert property (@(posedge ref_clk)
      disable iff (reset) frame_req.valid |=> frame_res.valid)
      else $error("result did not follow request by one cycle");

   a_idle_result: assert property (@(posedge ref_clk)
      disable iff (reset) !frame_req.valid |=> frame_res == '0)
      else $error("result shown without a request");

   a_upper_clear: assert property (@(posedge ref_clk)
      disable iff (reset) (frame_res.dest_mask >> PORTS) == '0)
      else $error("result holds a port beyond the served ports");

   a_mask_subset: assert property (@(posedge ref_clk)
      disable iff (reset) frame_req.valid |=>
      (frame_res.dest_mask & ~$past(frame_req.dest_mask)) == '0)
      else $error("result holds a port outside the port group mask");

   a_status_follows: assert property (@(posedge ref_clk)
      disable iff (reset) frame_req.valid |=>
      `LPMF_MAX_PORTS'(status_reg) == frame_res.dest_mask)
      else $error("status does not hold the last final mask");

   a_redirect_bypass: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && ctrl_reg[`LPMF_BYPASS_BIT] &&
       frame_req.mask_mode == `LPMF_REDIRECT_MODE)
      |=> frame_res.dest_mask[PORTS-1:0] ==
          $past(frame_req.dest_mask[PORTS-1:0]))
      else $error("redirect mode did not bypass the lag masks");

   a_reset_clears: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass &&
       (ctrl_reg[`LPMF_AGGR_EN_BIT] || ctrl_reg[`LPMF_CSD_EN_BIT]))
      |=> (frame_res.dest_mask[PORTS-1:0] & $past(rst_sel)) == '0)
      else $error("reset entry port survived");

   a_reset_index: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass && ctrl_reg[`LPMF_AGGR_EN_BIT]) |=>
      (frame_res.dest_mask[PORTS-1:0] &
       $past(rst_reg[frame_req.forwarder_group_profile])) == '0)
      else $error("profile reset entry not applied");

   a_hash_select: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass && ctrl_reg[`LPMF_AGGR_EN_BIT] &&
       !ctrl_reg[`LPMF_CSD_EN_BIT])
      |=> frame_res.dest_mask[PORTS-1:0] ==
          $past(frame_req.dest_mask[PORTS-1:0] &
                aggr_reg[frame_req.aggregation_hash_code] &
                ~rst_reg[frame_req.forwarder_group_profile]))
      else $error("hash code selection gave a wrong mask");

   a_outer_vid: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass && conv_src == LPMF_SRC_OUTER &&
       frame_req.tag_pop_count < frame_req.tag_count &&
       ctrl_reg[`LPMF_CSD_EN_BIT] && !ctrl_reg[`LPMF_AGGR_EN_BIT])
      |=> frame_res.dest_mask[PORTS-1:0] ==
          $past(frame_req.dest_mask[PORTS-1:0] & ~rst_sel &
                csd_reg[frame_req.tag_vid[frame_req.tag_pop_count]]))
      else $error("outer vid not taken after popped tags");

   a_generic_sel: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass && conv_src == LPMF_SRC_GENERIC &&
       ctrl_reg[`LPMF_CSD_EN_BIT] && !ctrl_reg[`LPMF_AGGR_EN_BIT])
      |=> frame_res.dest_mask[PORTS-1:0] ==
          $past(frame_req.dest_mask[PORTS-1:0] & ~rst_sel &
                csd_reg[frame_req.generic_vlan_id]))
      else $error("generic vid not used as conversation id");

   a_csd_write: assert property (@(posedge ref_clk)
      disable iff (reset)
      (reg_write && in_range(reg_addr, `LPMF_CSD_BASE, `LPMF_CSD_DEPTH))
      |=> csd_reg[$past(reg_addr[CSD_AW-1:0])] ==
          $past(reg_wdata[PORTS-1:0]))
      else $error("distribution table write lost");

   a_csd_only: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && !bypass && !ctrl_reg[`LPMF_AGGR_EN_BIT] &&
       ctrl_reg[`LPMF_CSD_EN_BIT] && rst_sel == '0)
      |=> frame_res.dest_mask[PORTS-1:0] ==
          ($past(frame_req.dest_mask[PORTS-1:0]) & $past(csd_sel)))
      else $error("conversation selection alone gave a wrong mask");

   a_nonaggr_keep: assert property (@(posedge ref_clk)
      disable iff (reset)
      (frame_req.valid && csd_sel == '1 && aggr_sel == '1 && rst_sel == '0)
      |=> frame_res.dest_mask[PORTS-1:0] ==
          $past(frame_req.dest_mask[PORTS-1:0]))
      else $error("all-ones entries changed the mask");

   a_read_once: assert property (@(posedge ref_clk)
      disable iff (reset) !reg_read |=> reg_rdata == '0)
      else $error("read data outside the answer cycle");

endmodule

`default_nettype wire

// *** hw/lpmf_cfg.svh ***
// constants for the aggregation port mask filter
`ifndef LPMF_CFG_SVH
`define LPMF_CFG_SVH

`define LPMF_ADDR_W       13
`define LPMF_DATA_W       32
`define LPMF_MAX_PORTS    32
`define LPMF_VID_W        12
`define LPMF_CSD_DEPTH    4096
`define LPMF_AGGR_DEPTH   16
`define LPMF_RST_DEPTH    32
`define LPMF_GROUPS       32

// register map, word addresses
`define LPMF_CTRL_ADDR    13'h0000
`define LPMF_STATUS_ADDR  13'h0001
`define LPMF_AGGR_BASE    13'h0010
`define LPMF_RST_BASE     13'h0020
`define LPMF_COUNT_BASE   13'h0040
`define LPMF_CSD_BASE     13'h1000

// control fields
`define LPMF_SEL_LSB      0
`define LPMF_SEL_MSB      1
`define LPMF_AGGR_EN_BIT  2
`define LPMF_CSD_EN_BIT   3
`define LPMF_BYPASS_BIT   4
`define LPMF_CTRL_W       5
`define LPMF_CTRL_RESET   5'h1c

`define LPMF_REDIRECT_MODE 3'h4

`endif

// *** hw/lpmf_pkg.sv ***
// types shared by the aggregation port mask filter
`default_nettype none

package lpmf_pkg;

   typedef enum logic [1:0] {
      LPMF_SRC_OUTER      = 2'b00,
      LPMF_SRC_CLASSIFIED = 2'b01,
      LPMF_SRC_GENERIC    = 2'b10
   } lpmf_source_type;

   typedef struct packed {
      logic              valid;
      logic [31:0]       dest_mask;       // port group destination mask
      logic [3:0]        aggregation_hash_code;
      logic [2:0][11:0]  tag_vid;         // received tags, [0] outermost
      logic [1:0]        tag_count;
      logic [1:0]        tag_pop_count;
      logic [11:0]       classified_vid;
      logic [11:0]       generic_vlan_id;
      logic [2:0]        mask_mode;
      logic [4:0]        forwarder_group_profile;
   } lpmf_req_type;

   typedef struct packed {
      logic              valid;
      logic [31:0]       dest_mask;
   } lpmf_res_type;

endpackage

`default_nettype wire

// *** test/lpmf_frame_source.sv ***
// partner model: classifier and port group lookup presenting frames
`timescale 1ns/100ps
`default_nettype none

module lpmf_frame_source
   import lpmf_pkg::*;
(
   input  wire logic         ref_clk,   // core clock
   input  wire logic         reset,     // async, active high
   input  wire logic         send,      // bench asks for one frame
   input  wire lpmf_req_type fields,    // frame content to present
   output lpmf_req_type      frame_req  // request towards the filter
);
   localparam int W = $bits(lpmf_req_type);

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         frame_req <= '0;
      end else if (send) begin
         // dest_mask is a plain port group entry; global group slots never
         // come through here, they resolve to unit and port upstream
         frame_req <= {1'b1, fields[W-2:0]};
      end else begin
         // idle fields flip every cycle so stale content is never trusted
         frame_req <= {1'b0, ~frame_req[W-2:0]};
      end
   end
endmodule

`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the aggregation port mask filter
`include "lpmf_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
   import lpmf_pkg::*;
   localparam int PORTS = 8;
   localparam int PMASK = (1 << PORTS) - 1;
   localparam logic [12:0] PROBE [9] = '{13'h0000, 13'h0001, 13'h001f,
      13'h003f, 13'h0040, 13'h005f, 13'h1000, 13'h1fff, 13'h0100};
   logic                    ref_clk;
   logic                    reset;
   logic                    reg_write;
   logic                    reg_read;
   logic                    send;
   logic [`LPMF_ADDR_W-1:0] reg_addr;
   logic [31:0]             reg_wdata;
   logic [31:0]             reg_rdata;
   logic [31:0]             rng;
   lpmf_req_type            frame_req;
   lpmf_req_type            fields;
   lpmf_res_type            frame_res;
   int                      errors;
   int                      num_checks;
   int ctrl_m, status_m, aggr_m[16], rst_m[32], cnt_m[32], csd_m[4096];
   int                      exp_q[$];

   lpmf_filter #(.PORTS(PORTS), .COUNT_W(8)) lpmf_filter_inst (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .frame_req(frame_req), .frame_res(frame_res));
   lpmf_frame_source lpmf_frame_source_inst (
      .ref_clk(ref_clk), .reset(reset), .send(send), .fields(fields),
      .frame_req(frame_req));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic int exp_reg(int a);
      if (a == 0) return ctrl_m;
      if (a == 1) return status_m;
      if (a >= 'h10 && a < 'h20) return aggr_m[a - 'h10];
      if (a >= 'h20 && a < 'h40) return rst_m[a - 'h20];
      if (a >= 'h40 && a < 'h60) return cnt_m[a - 'h40];
      if (a >= 'h1000 && a < 'h2000) return csd_m[a - 'h1000];
      return 0;
   endfunction

   function automatic int frame_exp(lpmf_req_type f);
      int conv;
      int a;
      int c;
      logic byp;
      case (ctrl_m & 3)
         0: conv = (f.tag_pop_count < f.tag_count) ?
                   f.tag_vid[f.tag_pop_count] : 0;
         2: conv = f.generic_vlan_id;
         default: conv = f.classified_vid;
      endcase
      byp = ctrl_m[4] && f.mask_mode == 3'h4;
      a = (ctrl_m[2] && !byp) ?
          aggr_m[f.aggregation_hash_code] & ~rst_m[f.forwarder_group_profile] : -1;
      c = (ctrl_m[3] && !byp) ?
          csd_m[conv] & ~rst_m[f.forwarder_group_profile] : -1;
      return f.dest_mask & a & c & PMASK;
   endfunction

   task automatic check_reg(input logic [12:0] a, input logic [31:0] e);
      num_checks++;
      if (reg_rdata !== e) begin
         errors++;
         $display("[FAIL] reg %h expected %h seen %h", a, e, reg_rdata);
      end
   endtask

   task automatic check_frame(input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] dest_mask expected %h seen %h", e, g);
      end
   endtask

   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      if (a == 0) ctrl_m = d & 32'h1f;
      else if (a >= 'h10 && a < 'h20) aggr_m[a - 'h10] = d & PMASK;
      else if (a >= 'h20 && a < 'h40) rst_m[a - 'h20] = d & PMASK;
      else if (a >= 'h40 && a < 'h60) cnt_m[a - 'h40] = d & 32'hff;
      else if (a >= 'h1000) csd_m[a - 'h1000] = d & PMASK;
   endtask

   task automatic rd(input logic [12:0] a);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check_reg(a, 32'(exp_reg(a)));
      @(posedge ref_clk);
      #1;
      check_reg(a, 32'h0);
   endtask

   task automatic frames(input int n);
      logic [127:0] r;
      lpmf_req_type f;
      for (int i = 0; i < n; i++) begin
         r = {xs(), xs(), xs(), xs()};
         f = r[108:0];
         if (r[127]) f.mask_mode = 3'h4;
         if (i == n - 1) begin
            // corner entries of the hash, profile and vid tables
            f.classified_vid = 12'hfff;
            f.generic_vlan_id = 12'hfff;
            f.forwarder_group_profile = 5'h1f;
            f.aggregation_hash_code = 4'hf;
         end
         @(posedge ref_clk);
         send   <= 1'b1;
         fields <= f;
         status_m = frame_exp(f);
         exp_q.push_back(status_m);
      end
      @(posedge ref_clk);
      send <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   always @(posedge ref_clk) begin
      if (reset === 1'b0 && frame_res.valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            errors++;
            $display("[FAIL] frame_res expected none seen %h", frame_res);
         end else begin
            check_frame(32'(exp_q.pop_front()), frame_res.dest_mask);
         end
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #(40000 * 100);
      errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      summarize();
   end

   initial begin
      errors = 0;
      num_checks = 0;
      rng = 32'he9e3;
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      send = 1'b0;
      fields = '0;
      ctrl_m = 'h1c;
      status_m = 0;
      foreach (aggr_m[i]) aggr_m[i] = PMASK;
      foreach (rst_m[i]) rst_m[i] = 0;
      foreach (cnt_m[i]) cnt_m[i] = 0;
      foreach (csd_m[i]) csd_m[i] = PMASK;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) rd(PROBE[i]);
      frames(6);
      $display("test reset_values done");
      for (int i = 0; i < 16; i++) wr(`LPMF_AGGR_BASE + 13'(i), xs());
      for (int i = 0; i < 32; i++) wr(`LPMF_RST_BASE + 13'(i), xs() & xs());
      for (int i = 0; i < 32; i++) wr(`LPMF_COUNT_BASE + 13'(i), xs());
      for (int i = 0; i < 4096; i++) wr(`LPMF_CSD_BASE + 13'(i), xs());
      wr(`LPMF_STATUS_ADDR, xs());
      wr(13'h0100, xs());
      for (int i = 0; i < 9; i++) rd(PROBE[i]);
      $display("test table_access done");
      for (int m = 0; m < 32; m++) begin
         wr(`LPMF_CTRL_ADDR, 32'(m));
         frames(8);
      end
      rd(`LPMF_STATUS_ADDR);
      $display("test mask_modes done");
      if (exp_q.size() != 0) begin
         errors++;
         $display("[FAIL] frames expected 0 pending seen %0d", exp_q.size());
      end
      summarize();
   end
endmodule

`default_nettype wire
